/* rtl/asbx_lapic_end.sv */
`include "asbx_consts.svh"
module asbx_lapic_end import asbx_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// Serial bus
	asbx_bus_if.lapic        bus,
	// Identity and arbitration
	input  wire logic [3:0]  bus_contender_id,
	input  wire logic [7:0]  logical_mask,
	input  wire logic [7:0]  proc_priority,
	input  wire logic        free_slot,
	// Message requests
	input  wire logic        req_valid,
	output logic             req_ready,
	input  asbx_msg_t        req_msg,
	output logic             req_done,
	output logic [3:0]       req_status,
	// Delivered interrupts
	output logic             irq_valid,
	output asbx_msg_t        irq_msg,
	// Register value served to remote reads
	input  wire logic [31:0] remote_read_value,
	input  wire logic        remote_read_ok,
	// Result of own remote read
	output logic             rd_valid,
	output logic [31:0]      rd_value,
	output logic             rd_ok
);
	logic [5:0]  cyc;
	logic [5:0]  last;
	logic [5:0]  next_cyc;
	logic [1:0]  next_lvl;
	logic [1:0]  st_seen;
	logic        pending;
	logic        sending;
	logic        next_sending;
	logic        contend;
	logic        next_contend;
	logic        resp;
	logic        next_resp;
	logic        mine_rr;
	logic        cks_bad;
	logic        start_now;
	logic        hit;
	logic        st0_ok_now;
	logic        plain_mode;
	logic [2:0]  rx_mode;
	logic [31:0] rx_data;
	logic [31:0] rd_hold;
	logic        rd_hold_ok;
	asbx_msg_t   tx_msg;
	asbx_msg_t   rx_msg;

	assign req_ready = !pending;
	assign rx_mode = rx_msg.delivery_mode_bits;
	assign plain_mode = rx_mode != `ASBX_DM_LOWEST && rx_mode != `ASBX_DM_REMOTE_READ;
	assign start_now = pending && !sending && cyc == 6'h00 && bus.line == `ASBX_LINE_IDLE;
	assign st0_ok_now = cyc == `ASBX_CYC_ST0 && bus.line == `ASBX_ST0_OK;
	assign hit = rx_msg.destination_mode ? |(rx_msg.destination_bits & logical_mask)
		: (rx_msg.destination_bits == {4'h0, bus_contender_id} || rx_msg.destination_bits == `ASBX_DEST_ALL);

	always_comb
	begin
		next_cyc = cyc;
		if (cyc == 6'h00)
		begin
			if (bus.line == `ASBX_LINE_START)
				next_cyc = `ASBX_CYC_ARB_FIRST;
		end
		else if (cyc == last)
			next_cyc = 6'h00;
		else
			next_cyc = cyc + 6'h01;
	end

	always_comb
	begin
		next_sending = sending;
		next_contend = contend;
		next_resp = resp;
		if (start_now)
			next_sending = 1'b1;
		if (sending && cyc <= `ASBX_CYC_ARB_LAST && bus.lap_out[1] && !bus.line[1])
			next_sending = 1'b0;
		if (cyc == `ASBX_CYC_ST1)
		begin
			next_sending = 1'b0;
			next_contend = !sending && !cks_bad && hit && free_slot && rx_mode == `ASBX_DM_LOWEST
				&& st_seen == `ASBX_ST0_OK && bus.line == `ASBX_ST1_LP_ARB;
			next_resp = !sending && !cks_bad && hit && rx_mode == `ASBX_DM_REMOTE_READ
				&& st_seen == `ASBX_ST0_OK;
		end
		// A dominant zero seen where this end released drops it out
		if (contend && cyc >= `ASBX_CYC_PRIO_FIRST && cyc <= `ASBX_CYC_TIE_LAST && bus.lap_out[1] && !bus.line[1])
			next_contend = 1'b0;
		if (next_cyc == 6'h00)
		begin
			next_contend = 1'b0;
			next_resp = 1'b0;
		end
	end

	always_comb
	begin
		next_lvl = `ASBX_LINE_IDLE;
		if (start_now)
			next_lvl = `ASBX_LINE_START;
		else if (next_sending)
		begin
			if (next_cyc <= `ASBX_CYC_ARB_LAST)
				next_lvl = {bus_contender_id[2'(`ASBX_CYC_ARB_LAST - next_cyc)], 1'b1};
			else if (next_cyc <= `ASBX_CYC_DATA_LAST)
				next_lvl = ~asbx_pick({tx_msg, 10'h000}, 6'(next_cyc - `ASBX_CYC_DATA_FIRST));
			else if (next_cyc == `ASBX_CYC_CKS)
				next_lvl = ~asbx_sum({10'h000, tx_msg});
		end
		else if (next_cyc == `ASBX_CYC_ST0 && cks_bad)
			next_lvl = `ASBX_ST0_CKS_ERR;
		else if (st0_ok_now && hit && !cks_bad && plain_mode)
			next_lvl = `ASBX_ST1_ACCEPT;
		else if (next_contend && next_cyc <= `ASBX_CYC_PRIO_LAST)
			next_lvl = {~proc_priority[3'(`ASBX_CYC_PRIO_LAST - next_cyc)], 1'b1};
		else if (next_contend && next_cyc <= `ASBX_CYC_TIE_LAST)
			next_lvl = {bus_contender_id[2'(`ASBX_CYC_TIE_LAST - next_cyc)], 1'b1};
		else if (next_contend && next_cyc == `ASBX_CYC_LP_STATUS)
			next_lvl = `ASBX_LP_WON;
		else if (next_resp && next_cyc <= `ASBX_CYC_RR_LAST)
			next_lvl = asbx_pick(rd_hold, 6'(next_cyc - `ASBX_CYC_RR_FIRST));
		else if (next_resp && next_cyc == `ASBX_CYC_RR_STATUS)
			next_lvl = rd_hold_ok ? `ASBX_RR_VALID : `ASBX_RR_INVALID;
		else if (next_resp && next_cyc == `ASBX_CYC_RR_CKS)
			next_lvl = asbx_sum(rd_hold);
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cyc <= 6'h00;
			last <= `ASBX_CYC_SHORT_IDLE;
		end
		else
		begin
			cyc <= next_cyc;
			if (cyc == 6'h00)
				last <= `ASBX_CYC_SHORT_IDLE;
			else if (cyc == `ASBX_CYC_ST1)
				last <= asbx_last_cycle(rx_mode, st_seen, bus.line);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_msg <= '0;
			rx_data <= 32'h0000_0000;
			st_seen <= `ASBX_LINE_IDLE;
			cks_bad <= 1'b0;
		end
		else
		begin
			if (cyc >= `ASBX_CYC_DATA_FIRST && cyc <= `ASBX_CYC_DATA_LAST)
				rx_msg <= {rx_msg[19:0], ~bus.line};
			if (cyc == `ASBX_CYC_CKS)
				cks_bad <= ~bus.line != asbx_sum({10'h000, rx_msg});
			if (cyc == `ASBX_CYC_ST0 || cyc == `ASBX_CYC_RR_STATUS)
				st_seen <= bus.line;
			if (cyc >= `ASBX_CYC_RR_FIRST && cyc <= `ASBX_CYC_RR_LAST)
				rx_data <= {rx_data[29:0], bus.line};
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sending <= 1'b0;
			contend <= 1'b0;
			resp <= 1'b0;
			bus.lap_out <= `ASBX_LINE_IDLE;
			bus.lap_oe <= 2'h0;
		end
		else
		begin
			sending <= next_sending;
			contend <= next_contend;
			resp <= next_resp;
			bus.lap_out <= next_lvl;
			bus.lap_oe <= ~next_lvl;
		end
	end

	// Snapshot so the served word cannot change mid-answer
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_hold <= 32'h0000_0000;
			rd_hold_ok <= 1'b0;
		end
		else if (cyc == `ASBX_CYC_ST0)
		begin
			rd_hold <= remote_read_value;
			rd_hold_ok <= remote_read_ok;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_valid <= 1'b0;
			irq_msg <= '0;
		end
		else
		begin
			irq_valid <= 1'b0;
			if ((cyc == `ASBX_CYC_ST1 && !sending && hit && !cks_bad && plain_mode && st_seen == `ASBX_ST0_OK)
				|| (cyc == `ASBX_CYC_LP_STATUS && contend))
			begin
				irq_valid <= 1'b1;
				irq_msg <= rx_msg;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pending <= 1'b0;
			tx_msg <= '0;
			req_done <= 1'b0;
			req_status <= `ASBX_STATUS_REFUSED;
			mine_rr <= 1'b0;
		end
		else
		begin
			req_done <= 1'b0;
			if (req_valid && !pending)
			begin
				pending <= 1'b1;
				tx_msg <= req_msg;
			end
			if (sending && cyc == `ASBX_CYC_ST1)
			begin
				mine_rr <= tx_msg.delivery_mode_bits == `ASBX_DM_REMOTE_READ;
				// A remote read is finished whatever its status says
				if (st_seen != `ASBX_ST0_CKS_ERR || tx_msg.delivery_mode_bits == `ASBX_DM_REMOTE_READ)
				begin
					pending <= 1'b0;
					req_done <= 1'b1;
					req_status <= {st_seen, bus.line};
				end
			end
			else if (next_cyc == 6'h00)
				mine_rr <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_valid <= 1'b0;
			rd_value <= 32'h0000_0000;
			rd_ok <= 1'b0;
		end
		else
		begin
			rd_valid <= mine_rr && cyc == `ASBX_CYC_RR_CKS;
			if (mine_rr && cyc == `ASBX_CYC_RR_CKS)
			begin
				rd_value <= rx_data;
				rd_ok <= st_seen == `ASBX_RR_VALID && bus.line == asbx_sum(rx_data);
			end
		end
	end
endmodule

/* rtl/asbx_consts.svh */
`ifndef ASBX_CONSTS_SVH
`define ASBX_CONSTS_SVH
`define ASBX_CYC_ARB_FIRST   6'h02
`define ASBX_CYC_ARB_LAST    6'h05
`define ASBX_CYC_DATA_FIRST  6'h06
`define ASBX_CYC_DATA_LAST   6'h10
`define ASBX_CYC_CKS         6'h11
`define ASBX_CYC_ST0         6'h13
`define ASBX_CYC_ST1         6'h14
`define ASBX_CYC_SHORT_IDLE  6'h15
`define ASBX_CYC_PRIO_FIRST  6'h15
`define ASBX_CYC_PRIO_LAST   6'h1C
`define ASBX_CYC_TIE_LAST    6'h20
`define ASBX_CYC_LP_STATUS   6'h21
`define ASBX_CYC_LP_IDLE     6'h22
`define ASBX_CYC_RR_FIRST    6'h15
`define ASBX_CYC_RR_LAST     6'h24
`define ASBX_CYC_RR_STATUS   6'h25
`define ASBX_CYC_RR_CKS      6'h26
`define ASBX_CYC_RR_IDLE     6'h27
`define ASBX_LINE_IDLE       2'h3
`define ASBX_LINE_START      2'h2
`define ASBX_ST0_OK          2'h3
`define ASBX_ST0_CKS_ERR     2'h0
`define ASBX_ST1_LP_ARB      2'h3
`define ASBX_ST1_ACCEPT      2'h1
`define ASBX_LP_WON          2'h1
`define ASBX_RR_VALID        2'h0
`define ASBX_RR_INVALID      2'h3
`define ASBX_DM_LOWEST       3'h1
`define ASBX_DM_REMOTE_READ  3'h3
`define ASBX_DEST_ALL        8'hFF
`define ASBX_STATUS_REFUSED  4'h0
`endif

/* rtl/asbx_pkg.sv */
`include "asbx_consts.svh"
package asbx_pkg;
	typedef struct packed {
		logic       destination_mode;
		logic [2:0] delivery_mode_bits;
		logic       level;
		logic       trigger_mode;
		logic [7:0] vector_bits;
		logic [7:0] destination_bits;
	} asbx_msg_t;

	// Mod-4 sum of all bits; narrower fields are zero extended
	function automatic logic [1:0] asbx_sum(input logic [31:0] v);
		logic [1:0] s;
		s = 2'h0;
		for (int i = 0; i < 32; i++)
			s = s + {1'b0, v[i]};
		return s;
	endfunction

	// Pair idx counted from the most significant end
	function automatic logic [1:0] asbx_pick(input logic [31:0] v, input logic [5:0] idx);
		logic [31:0] s;
		s = v << {idx, 1'b0};
		return s[31:30];
	endfunction

	function automatic logic [5:0] asbx_last_cycle(input logic [2:0] mode, input logic [1:0] st0,
		input logic [1:0] st1);
		if (mode == `ASBX_DM_REMOTE_READ)
			return `ASBX_CYC_RR_IDLE;
		if (mode == `ASBX_DM_LOWEST && st0 == `ASBX_ST0_OK && st1 == `ASBX_ST1_LP_ARB)
			return `ASBX_CYC_LP_IDLE;
		return `ASBX_CYC_SHORT_IDLE;
	endfunction
endpackage

/* rtl/asbx_bus_if.sv */
interface asbx_bus_if;
	logic [1:0] dev_out;
	logic [1:0] dev_oe;
	logic [1:0] lap_out;
	logic [1:0] lap_oe;
	logic [1:0] ext_line;
	logic [1:0] line;

	// Open drain: a released party reads high, any low drive wins
	assign line = (dev_out | ~dev_oe) & (lap_out | ~lap_oe) & ext_line;

	modport iodev (input line, output dev_out, output dev_oe);
	modport lapic (input line, output lap_out, output lap_oe);
endinterface

/* rtl/asbx_ioapic_end.sv */
`include "asbx_consts.svh"
module asbx_ioapic_end import asbx_pkg::*;
(
	// Clock and reset
	input  wire logic       core_clk,
	input  wire logic       arst_n,
	// Serial bus
	asbx_bus_if.iodev       bus,
	// Sender identity
	input  wire logic [3:0] bus_contender_id,
	// Message requests
	input  wire logic       req_valid,
	output logic            req_ready,
	input  asbx_msg_t       req_msg,
	output logic            req_done,
	output logic [3:0]      req_status,
	// Bus observation
	output logic            busy,
	output logic            rr_seen
);
	logic [5:0] cyc;
	logic [5:0] last;
	logic [5:0] next_cyc;
	logic [1:0] next_lvl;
	logic [1:0] st_seen;
	logic       pending;
	logic       sending;
	logic       next_sending;
	logic       cks_bad;
	logic       start_now;
	logic [2:0] rx_mode;
	asbx_msg_t  tx_msg;
	asbx_msg_t  rx_msg;

	assign req_ready = !pending;
	assign busy = cyc != 6'h00;
	assign rx_mode = rx_msg.delivery_mode_bits;
	assign start_now = pending && !sending && cyc == 6'h00 && bus.line == `ASBX_LINE_IDLE;

	always_comb
	begin
		next_cyc = cyc;
		if (cyc == 6'h00)
		begin
			if (bus.line == `ASBX_LINE_START)
				next_cyc = `ASBX_CYC_ARB_FIRST;
		end
		else if (cyc == last)
			next_cyc = 6'h00;
		else
			next_cyc = cyc + 6'h01;
	end

	always_comb
	begin
		next_sending = sending;
		if (start_now)
			next_sending = 1'b1;
		// Released a one but saw a zero: another sender owns the bus
		if (sending && cyc <= `ASBX_CYC_ARB_LAST && bus.dev_out[1] && !bus.line[1])
			next_sending = 1'b0;
		if (cyc == `ASBX_CYC_ST1)
			next_sending = 1'b0;
	end

	always_comb
	begin
		next_lvl = `ASBX_LINE_IDLE;
		if (start_now)
			next_lvl = `ASBX_LINE_START;
		else if (next_sending)
		begin
			if (next_cyc <= `ASBX_CYC_ARB_LAST)
				next_lvl = {bus_contender_id[2'(`ASBX_CYC_ARB_LAST - next_cyc)], 1'b1};
			else if (next_cyc <= `ASBX_CYC_DATA_LAST)
				next_lvl = ~asbx_pick({tx_msg, 10'h000}, 6'(next_cyc - `ASBX_CYC_DATA_FIRST));
			else if (next_cyc == `ASBX_CYC_CKS)
				next_lvl = ~asbx_sum({10'h000, tx_msg});
		end
		// No status answer to a remote read, even a corrupt one
		else if (next_cyc == `ASBX_CYC_ST0 && cks_bad && rx_mode != `ASBX_DM_REMOTE_READ)
			next_lvl = `ASBX_ST0_CKS_ERR;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cyc <= 6'h00;
			last <= `ASBX_CYC_SHORT_IDLE;
		end
		else
		begin
			cyc <= next_cyc;
			if (cyc == 6'h00)
				last <= `ASBX_CYC_SHORT_IDLE;
			else if (cyc == `ASBX_CYC_ST1)
				last <= asbx_last_cycle(rx_mode, st_seen, bus.line);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rx_msg <= '0;
			st_seen <= `ASBX_LINE_IDLE;
			cks_bad <= 1'b0;
		end
		else
		begin
			if (cyc >= `ASBX_CYC_DATA_FIRST && cyc <= `ASBX_CYC_DATA_LAST)
				rx_msg <= {rx_msg[19:0], ~bus.line};
			if (cyc == `ASBX_CYC_CKS)
				cks_bad <= ~bus.line != asbx_sum({10'h000, rx_msg});
			if (cyc == `ASBX_CYC_ST0)
				st_seen <= bus.line;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sending <= 1'b0;
			bus.dev_out <= `ASBX_LINE_IDLE;
			bus.dev_oe <= 2'h0;
		end
		else
		begin
			sending <= next_sending;
			bus.dev_out <= next_lvl;
			bus.dev_oe <= ~next_lvl;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pending <= 1'b0;
			tx_msg <= '0;
			req_done <= 1'b0;
			req_status <= `ASBX_STATUS_REFUSED;
			rr_seen <= 1'b0;
		end
		else
		begin
			req_done <= 1'b0;
			rr_seen <= cyc == `ASBX_CYC_RR_IDLE && next_cyc == 6'h00;
			if (req_valid && !pending)
			begin
				tx_msg <= req_msg;
				// Remote reads are refused at once rather than sent
				if (req_msg.delivery_mode_bits == `ASBX_DM_REMOTE_READ)
				begin
					req_done <= 1'b1;
					req_status <= `ASBX_STATUS_REFUSED;
				end
				else
					pending <= 1'b1;
			end
			if (sending && cyc == `ASBX_CYC_ST1 && st_seen != `ASBX_ST0_CKS_ERR)
			begin
				pending <= 1'b0;
				req_done <= 1'b1;
				req_status <= {st_seen, bus.line};
			end
		end
	end
endmodule

/* tb/asbx_bus_props.sv */
`include "asbx_consts.svh"
module asbx_bus_props (
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       arst_n,
	// Interface signals
	input wire logic [1:0] dev_out,
	input wire logic [1:0] dev_oe,
	input wire logic [1:0] lap_out,
	input wire logic [1:0] lap_oe,
	input wire logic [1:0] ext_line,
	input wire logic [1:0] line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [5:0] cyc;
	logic [5:0] last;
	logic [2:0] mode;
	logic [1:0] st0, st1, st37, acc, dsum;
	logic       lp, rr;

	assign rr = mode == `ASBX_DM_REMOTE_READ;
	assign lp = mode == `ASBX_DM_LOWEST && st0 == 2'h3 && st1 == 2'h3;
	assign last = rr ? 6'h27 : (lp ? 6'h22 : 6'h15);

	// Position rebuilt from the wire alone, so a slip in either end shows
	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			cyc <= 6'h00;
		else if (cyc == 6'h00)
			cyc <= (line == 2'h2) ? 6'h02 : 6'h00;
		else if (cyc == last)
			cyc <= 6'h00;
		else
			cyc <= cyc + 6'h01;

	always_ff @(posedge core_clk or negedge arst_n)
		if (!arst_n)
			{mode, st0, st1, st37, acc, dsum} <= '0;
		else
		begin
			if (cyc == 6'h02) {acc, dsum} <= 4'h0;
			if (cyc >= 6'h06 && cyc <= 6'h10) acc <= acc + {1'b0, ~line[1]} + {1'b0, ~line[0]};
			if (cyc >= 6'h15 && cyc <= 6'h24) dsum <= dsum + {1'b0, line[1]} + {1'b0, line[0]};
			if (cyc == 6'h06) mode[2] <= ~line[0];
			if (cyc == 6'h07) mode[1:0] <= ~line;
			if (cyc == 6'h13) st0 <= line;
			if (cyc == 6'h14) st1 <= line;
			if (cyc == 6'h25) st37 <= line;
		end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	arb_id_bit_a: assert property (cyc >= 6'h02 && cyc <= 6'h05 |-> line[0])
		else $error("id cycle bit 0 low");
	postamble_a: assert property (cyc == 6'h11 |=> line == 2'h3)
		else $error("postamble not idle");
	checksum_a: assert property (cyc == 6'h11 |-> line == ~acc)
		else $error("header checksum wrong");
	prio_frame_a: assert property (lp && cyc == 6'h15 |-> line[0] [*8] ##1 line[0] [*4])
		else $error("arbitration bit 0 low");
	prio_bit0_a: assert property (lp && cyc >= 6'h15 && cyc <= 6'h20 |-> lap_out[0])
		else $error("processor end pulls bit 0 in arbitration");
	frame_end_a: assert property (cyc != 6'h00 && cyc == last |-> line == 2'h3)
		else $error("end cycle not idle");
	rr_status_a: assert property (rr && cyc == 6'h25 |-> line inside {2'h0, 2'h3})
		else $error("read status code bad");
	rr_sum_a: assert property (rr && cyc == 6'h26 && st37 == 2'h0 |-> line == dsum)
		else $error("read checksum wrong");
	io_quiet_rr_a: assert property (rr && cyc >= 6'h13 |-> dev_oe == 2'h0)
		else $error("io end drives in read");
	io_quiet_lp_a: assert property (lp && cyc >= 6'h15 |-> dev_oe == 2'h0)
		else $error("io end drives priority");

	cover property (lp && cyc == 6'h21 && line == 2'h1);
	cover property (rr && cyc == 6'h26 && st37 == 2'h0);
	cover property (cyc == 6'h13 && line == 2'h0);
	cover property (cyc == 6'h14 && line == 2'h1);
endmodule

/* tb/apic_serial_bus_extended_msgs_test.sv */
module apic_serial_bus_extended_msgs_test import asbx_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [3:0]  io_id   = 4'h9;
	localparam logic [3:0]  lap_id  = 4'h5;
	localparam logic [3:0]  ext_id  = 4'h2;
	localparam logic [31:0] rd_word = 32'hA5C30F96;
	localparam logic [31:0] rr_val  = 32'h13579BDF;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        io_valid, lap_valid, free_slot, ext_on, one_shot;
	logic        io_ready, io_done, io_busy, rr_seen, lap_ready, lap_done, irq_valid, rd_valid, rd_ok, rd_k;
	logic [3:0]  io_status, lap_status, io_st;
	logic [7:0]  prio = 8'h3C;
	logic [7:0]  mask = 8'h10;
	logic [31:0] rd_value, rd_v;
	logic [5:0]  cyc;
	logic [1:0]  ext_drv = 2'h3;
	logic        rr_ok = 1'b1;
	logic [1:0]  seen [0:63];
	logic [1:0]  pat [0:63];
	asbx_msg_t   io_msg, lap_msg, irq_msg, irq_m, m;
	int          n_errors = 0, samples_checked = 0, n_irq = 0, n_rr = 0, n_frames = 0, ticks = 0;
	int          n_io = 0, n_lap = 0, n_busy = 0, f0, i0, r0, b0;

	always #2 core_clk = ~core_clk;

	asbx_bus_if asbx_bus_if_i ();
	assign asbx_bus_if_i.ext_line = ext_drv;
	assign cyc = props_i.cyc;

	asbx_ioapic_end asbx_ioapic_end_i (.core_clk, .arst_n, .bus(asbx_bus_if_i), .bus_contender_id(io_id),
		.req_valid(io_valid), .req_ready(io_ready), .req_msg(io_msg), .req_done(io_done),
		.req_status(io_status), .busy(io_busy), .rr_seen);
	asbx_lapic_end asbx_lapic_end_i (.core_clk, .arst_n, .bus(asbx_bus_if_i), .bus_contender_id(lap_id),
		.logical_mask(mask), .proc_priority(prio), .free_slot, .req_valid(lap_valid), .req_ready(lap_ready),
		.req_msg(lap_msg), .req_done(lap_done), .req_status(lap_status), .irq_valid, .irq_msg,
		.remote_read_value(rr_val), .remote_read_ok(rr_ok), .rd_valid, .rd_value, .rd_ok);
	asbx_bus_props props_i (.core_clk, .arst_n, .dev_out(asbx_bus_if_i.dev_out), .dev_oe(asbx_bus_if_i.dev_oe),
		.lap_out(asbx_bus_if_i.lap_out), .lap_oe(asbx_bus_if_i.lap_oe), .ext_line(asbx_bus_if_i.ext_line),
		.line(asbx_bus_if_i.line));

	// Other bus parties are played through the wired-AND input, cycle by cycle
	always @(negedge core_clk)
	begin
		ext_drv <= ext_on ? pat[cyc] : 2'h3;
		if (one_shot && cyc == 6'h14) ext_on <= 1'b0;
	end

	always @(posedge core_clk)
	begin
		seen[cyc] <= asbx_bus_if_i.line;
		if (io_done) n_io++;
		if (io_done) io_st <= io_status;
		if (lap_done) n_lap++;
		if (irq_valid) n_irq++;
		if (irq_valid) irq_m <= irq_msg;
		if (rd_valid) {rd_k, rd_v} <= {rd_ok, rd_value};
		if (rr_seen) n_rr++;
		if (io_busy) n_busy++;
		if (cyc == 6'h02) n_frames++;
		if (++ticks > 5000)
		begin
			n_errors++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [1:0] msum(input logic [31:0] v);
		logic [1:0] s;
		s = 2'h0;
		for (int i = 0; i < 32; i++) s = s + {1'b0, v[i]};
		return s;
	endfunction

	// Holds the request until taken, then waits out the whole frame
	task automatic send(input logic lap, input asbx_msg_t r);
		int d;
		int k;
		d = lap ? n_lap : n_io;
		@(negedge core_clk);
		if (lap) lap_msg = r;
		else io_msg = r;
		{lap_valid, io_valid} = {lap, !lap};
		do @(posedge core_clk); while ((lap ? lap_ready : io_ready) !== 1'b1);
		@(negedge core_clk);
		{lap_valid, io_valid} = 2'h0;
		for (k = 0; k < 300 && (lap ? n_lap : n_io) == d; k++) @(negedge core_clk);
		for (k = 0; k < 60 && cyc != 6'h00; k++) @(negedge core_clk);
		repeat (3) @(negedge core_clk);
	endtask

	task automatic hdr(input asbx_msg_t h);
		for (int i = 0; i < 4; i++) chk("arb id", seen[2 + i], {io_id[3 - i], 1'b1});
		for (int i = 0; i < 11; i++) chk("data", seen[6 + i], {~h[21 - 2 * i -: 2]});
		chk("checksum", seen[17], {~msum(32'(h))});
		chk("postamble", seen[18], 2'h3);
	endtask

	task automatic clr();
		for (int i = 0; i < 64; i++) pat[i] = 2'h3;
	endtask

	initial
	begin
		{io_valid, lap_valid, ext_on, one_shot, free_slot} = 5'h01;
		{io_msg, lap_msg} = '0;
		clr();
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		arst_n = 1'b1;
		for (int md = 0; md < 8; md++)
			if (md != 1 && md != 3)
			begin
				m = {1'b0, md[2:0], md[1:0], 8'h31 + 8'(md), 4'h0, lap_id};
				i0 = n_irq;
				send(1'b0, m);
				hdr(m);
				chk("status", io_st, 4'hD);
				chk("irq msg", irq_m, m);
				chk("irq count", n_irq - i0, 1);
			end
		m = {1'b1, 3'h1, 2'h0, 8'h5A, 8'hFF};
		i0 = n_irq;
		b0 = n_busy;
		send(1'b0, m);
		hdr(m);
		chk("lp status", io_st, 4'hF);
		chk("lp busy", n_busy - b0, 33);
		for (int i = 0; i < 8; i++) chk("prio", seen[21 + i], {~prio[7 - i], 1'b1});
		for (int i = 0; i < 4; i++) chk("tie id", seen[29 + i], {lap_id[3 - i], 1'b1});
		chk("won", seen[33], 2'h1);
		chk("lp idle", seen[34], 2'h3);
		chk("lp irq", n_irq - i0, 1);
		free_slot = 1'b0;
		i0 = n_irq;
		send(1'b0, m);
		for (int i = 0; i < 8; i++) chk("no prio", seen[21 + i], 2'h3);
		chk("full irq", n_irq - i0, 0);
		free_slot = 1'b1;
		prio = 8'h81;
		for (int i = 0; i < 8; i++) pat[21 + i] = {~prio[7 - i], 1'b1};
		for (int i = 0; i < 4; i++) pat[29 + i] = {ext_id[3 - i], 1'b1};
		pat[33] = 2'h1;
		ext_on = 1'b1;
		i0 = n_irq;
		send(1'b0, m);
		ext_on = 1'b0;
		for (int i = 0; i < 4; i++) chk("tie", seen[29 + i], {ext_id[3 - i], 1'b1});
		chk("tie lost", n_irq - i0, 0);
		clr();
		pat[19] = 2'h0;
		{ext_on, one_shot} = 2'h3;
		f0 = n_frames;
		m = {1'b0, 3'h0, 2'h0, 8'hC7, 4'h0, lap_id};
		send(1'b0, m);
		one_shot = 1'b0;
		chk("resent", n_frames - f0, 2);
		chk("resent status", io_st, 4'hD);
		f0 = n_frames;
		send(1'b0, {1'b0, 3'h3, 2'h0, 8'h00, 8'hFF});
		chk("refused", io_st, 4'h0);
		chk("no frame", n_frames - f0, 0);
		f0 = n_frames;
		r0 = n_rr;
		m = {1'b0, 3'h3, 2'h0, 8'h00, 4'h0, io_id};
		send(1'b1, m);
		chk("rr invalid", rd_k, 1'b0);
		chk("rr once", n_frames - f0, 1);
		chk("rr seen", n_rr - r0, 1);
		chk("rr status", lap_status, 4'hF);
		clr();
		for (int i = 0; i < 16; i++) pat[21 + i] = rd_word[31 - 2 * i -: 2];
		pat[37] = 2'h0;
		pat[38] = msum(rd_word);
		ext_on = 1'b1;
		send(1'b1, m);
		ext_on = 1'b0;
		chk("rr value", rd_v, rd_word);
		chk("rr valid", rd_k, 1'b1);
		// A far party reads the processor end, which must answer from its own register
		clr();
		pat[0] = 2'h2;
		m = {1'b0, 3'h3, 2'h0, 8'h00, 4'h0, lap_id};
		for (int i = 0; i < 4; i++) pat[2 + i] = {ext_id[3 - i], 1'b1};
		for (int i = 0; i < 11; i++) pat[6 + i] = ~m[21 - 2 * i -: 2];
		pat[17] = ~msum(32'(m));
		one_shot = 1'b1;
		for (int v = 0; v < 2; v++)
		begin
			rr_ok = v[0];
			ext_on = 1'b1;
			repeat (50) @(negedge core_clk);
			for (int i = 0; i < 16; i++) chk("rr answer", seen[21 + i], rr_val[31 - 2 * i -: 2]);
			chk("rr answer status", seen[37], v[0] ? 2'h0 : 2'h3);
			chk("rr answer sum", seen[38], msum(rr_val));
		end
		one_shot = 1'b0;
		conclude();
	end
endmodule
